//--- smsc_core.sv
`timescale 1ns/1ps
module smsc_core (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   ctl_wr,
  input  wire smsc_pkg::smsc_ctl_type ctl_wdata,
  input  wire logic                   sta_rd,
  input  wire logic                   dat_wr,
  input  wire logic [7:0]             dat_wdata,
  input  wire logic                   dat_rd,
  output smsc_pkg::smsc_ctl_type      ctl_rdata,
  output smsc_pkg::smsc_sta_type      sta_rdata,
  output logic [7:0]                  dat_rdata,
  output logic                        busy,
  input  wire logic                   sck_in,
  output logic                        sck_out,
  output logic                        sck_oe,
  input  wire logic                   mosi_in,
  output logic                        mosi_out,
  output logic                        mosi_oe,
  input  wire logic                   miso_in,
  output logic                        miso_out,
  output logic                        miso_oe,
  input  wire logic                   ss_n_in
);

  smsc_pkg::smsc_ctl_type ctl_q;
  smsc_pkg::smsc_ctl_type ctl_d;
  smsc_pkg::smsc_sta_type sta_q;
  smsc_pkg::smsc_sta_type sta_d;
  smsc_pkg::smsc_sta_type arm_q;
  smsc_pkg::smsc_sta_type arm_d;
  logic [7:0]             shreg_q;
  logic [7:0]             shreg_d;
  logic [7:0]             rx_q;
  logic [7:0]             rx_d;
  logic [7:0]             final_byte;
  logic                   sample_q;
  logic                   sample_d;
  logic                   new_bit;
  logic [3:0]             edge_q;
  logic [3:0]             edge_d;
  logic                   busy_q;
  logic                   busy_d;
  logic                   loaded_q;
  logic                   loaded_d;
  logic                   sck_q;
  logic                   sck_d;
  logic                   sckp_q;
  logic                   done_q;
  logic                   done_d;
  logic                   sck_oe_d;
  logic                   mosi_oe_d;
  logic                   miso_oe_d;
  logic [3:0]             sy;
  logic                   sck_s;
  logic                   ss_s;
  logic                   mosi_s;
  logic                   miso_s;
  logic                   tick;
  logic                   master;
  logic                   slave_cfg;
  logic                   ss_ignore;
  logic                   selected;
  logic                   slave_on;
  logic                   mode_fault_flag_ev;
  logic                   xfer_edge;
  logic                   capture;
  logic [4:0]             tog_q;
  logic                   sck_seen_q;

  smsc_sync #(
    .WIDTH(4)
  ) u_sync (
    .mclk    (mclk),
    .nrst    (nrst),
    .async_in({sck_in, ss_n_in, mosi_in, miso_in}),
    .sync_out(sy)
  );

  // Pins are synchronised before any edge detection
  assign sck_s  = sy[3];
  assign ss_s   = sy[2];
  assign mosi_s = sy[1];
  assign miso_s = sy[0];

  smsc_rate_gen u_rate (
    .mclk(mclk),
    .nrst(nrst),
    .run (master & busy_q),
    .rate({ctl_q.rate_select_bits, ctl_q.rate_select_mid, ctl_q.rate_select_low}),
    .tick(tick)
  );

  // Mode and select decode
  always_comb begin
    master    = ctl_q.spi_on & ctl_q.master_select;
    slave_cfg = ctl_q.spi_on & !ctl_q.master_select;
    ss_ignore = ctl_q.select_input_disable & (master | ctl_q.clock_phase);
    selected  = ss_ignore | !ss_s;
    slave_on  = slave_cfg & loaded_q & selected;
    mode_fault_flag_ev   = master & !ctl_q.select_input_disable & !ss_s;
    xfer_edge = master ? (busy_q & tick) : (slave_on & (sck_s ^ sckp_q));
    capture   = !edge_q[0] ^ ctl_q.clock_phase;
    new_bit   = master ? miso_s : mosi_s;
    final_byte = {shreg_q[6:0], ctl_q.clock_phase ? new_bit : sample_q};
  end

  // Transfer engine
  always_comb begin
    shreg_d  = shreg_q;
    rx_d     = rx_q;
    sample_d = sample_q;
    edge_d   = edge_q;
    busy_d   = busy_q;
    loaded_d = loaded_q;
    done_d   = 1'b0;
    if (dat_wr && !busy_q) begin
      shreg_d = dat_wdata;
      if (master) begin
        busy_d = 1'b1;
        edge_d = smsc_pkg::EDGE_ZERO;
      end else begin
        loaded_d = 1'b1;
      end
    end else if (xfer_edge) begin
      busy_d = 1'b1;
      edge_d = edge_q + 4'h1;
      if (capture) begin
        sample_d = new_bit;
      end else if (!(ctl_q.clock_phase && edge_q == smsc_pkg::EDGE_ZERO)) begin
        shreg_d = {shreg_q[6:0], sample_q};
      end
      if (edge_q == smsc_pkg::EDGE_LAST) begin
        shreg_d  = final_byte;
        rx_d     = final_byte;
        busy_d   = 1'b0;
        edge_d   = smsc_pkg::EDGE_ZERO;
        loaded_d = 1'b0;
        done_d   = 1'b1;
      end
    end
    if (slave_cfg && !selected) begin
      busy_d = 1'b0;
      edge_d = smsc_pkg::EDGE_ZERO;
    end
    if (mode_fault_flag_ev || !ctl_d.spi_on || (ctl_d.master_select != ctl_q.master_select)) begin
      busy_d = 1'b0;
      edge_d = smsc_pkg::EDGE_ZERO;
    end
  end

  // Control register and status flags
  always_comb begin
    ctl_d = ctl_q;
    sta_d = sta_q;
    arm_d = arm_q;
    if (ctl_wr) begin
      ctl_d = ctl_wdata;
    end
    if (sta_rd) begin
      arm_d = sta_q;
    end
    if (arm_q.transfer_done_flag && (dat_rd || dat_wr)) begin
      sta_d.transfer_done_flag = 1'b0;
      arm_d.transfer_done_flag = 1'b0;
    end
    if (arm_q.write_collision_flag && dat_wr && !busy_q) begin
      sta_d.write_collision_flag = 1'b0;
      arm_d.write_collision_flag = 1'b0;
    end
    if (arm_q.mode_fault_flag && ctl_wr) begin
      sta_d.mode_fault_flag = 1'b0;
      arm_d.mode_fault_flag = 1'b0;
    end
    if (done_d) begin
      sta_d.transfer_done_flag = 1'b1;
    end
    if (dat_wr && busy_q) begin
      sta_d.write_collision_flag = 1'b1;
    end
    if (mode_fault_flag_ev) begin
      ctl_d.spi_on          = 1'b0;
      ctl_d.master_select   = 1'b0;
      sta_d.mode_fault_flag = 1'b1;
    end
  end

  // Pin drive
  always_comb begin
    sck_d     = ctl_q.spi_on ? ctl_q.clock_polarity_sel : 1'b1;
    if (master && busy_q) begin
      sck_d = tick ? !sck_q : sck_q;
    end
    sck_oe_d  = master;
    mosi_oe_d = master;
    miso_oe_d = slave_on;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctl_q    <= smsc_pkg::CTL_RST;
      sta_q    <= smsc_pkg::STA_RST;
      arm_q    <= smsc_pkg::STA_RST;
      shreg_q  <= 8'h00;
      rx_q     <= 8'h00;
      sample_q <= 1'b0;
      edge_q   <= 4'h0;
      busy_q   <= 1'b0;
      loaded_q <= 1'b0;
      done_q   <= 1'b0;
      sck_q    <= 1'b1;
      sckp_q   <= 1'b1;
      sck_oe   <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      ctl_q    <= ctl_d;
      sta_q    <= sta_d;
      arm_q    <= arm_d;
      shreg_q  <= shreg_d;
      rx_q     <= rx_d;
      sample_q <= sample_d;
      edge_q   <= edge_d;
      busy_q   <= busy_d;
      loaded_q <= loaded_d;
      done_q   <= done_d;
      sck_q    <= sck_d;
      sckp_q   <= sck_s;
      sck_oe   <= sck_oe_d;
      mosi_oe  <= mosi_oe_d;
      miso_oe  <= miso_oe_d;
    end
  end

  assign ctl_rdata = ctl_q;
  assign sta_rdata = sta_q;
  assign dat_rdata = rx_q;
  assign busy      = busy_q;
  assign sck_out   = sck_q;
  assign mosi_out  = shreg_q[7];
  assign miso_out  = shreg_q[7];

  // Helper: counts SCK toggles seen during a master transfer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tog_q      <= 5'h00;
      sck_seen_q <= 1'b1;
    end else begin
      sck_seen_q <= sck_q;
      if (!busy_q) begin
        tog_q <= 5'h00;
      end else if (sck_q != sck_seen_q) begin
        tog_q <= tog_q + 5'h01;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_mosi_drive: assert property (
    mosi_oe |-> $past(ctl_q.master_select) && $past(ctl_q.spi_on))
    else $error("MOSI driven outside master mode");

  chk_miso_drive: assert property (
    miso_oe |-> !$past(ctl_q.master_select) && $past(loaded_q))
    else $error("MISO driven while not an active slave");

  chk_eight_clocks: assert property (
    done_q && ctl_q.master_select |-> tog_q == smsc_pkg::TOG_LAST && sck_q != sck_seen_q)
    else $error("Master byte did not give eight SCK cycles");

  chk_write_start: assert property (
    dat_wr && master && !busy_q && !mode_fault_flag_ev && !ctl_wr |=> busy_q && shreg_q == $past(dat_wdata))
    else $error("Data write did not start master transfer");

  chk_rx_holding: assert property (
    done_d |=> dat_rdata == $past(final_byte) ##1 dat_rdata == $past(dat_rdata))
    else $error("Receive holding register wrong after transfer");

  chk_done_set: assert property (
    done_q |-> sta_q.transfer_done_flag && !busy_q)
    else $error("Done flag not set at end of byte");

  chk_done_hold: assert property (
    sta_q.transfer_done_flag && !arm_q.transfer_done_flag |=> sta_q.transfer_done_flag)
    else $error("Done flag cleared without status read");

  chk_mode_fault: assert property (
    mode_fault_flag_ev |=> !ctl_q.spi_on && !ctl_q.master_select && sta_q.mode_fault_flag && !busy_q)
    else $error("Mode fault did not disable controller");

  chk_write_coll: assert property (
    dat_wr && busy_q && !mode_fault_flag_ev && !ctl_wr && !done_d |=> busy_q && sta_q.write_collision_flag)
    else $error("Collision write disturbed transfer");

  chk_sck_idle: assert property (
    !busy_q && ctl_q.spi_on && !ctl_wr && !mode_fault_flag_ev ##1 !busy_q |-> sck_q == ctl_q.clock_polarity_sel)
    else $error("SCK not at idle polarity");

endmodule

//--- smsc_pkg.sv
package smsc_pkg;

  typedef struct packed {
    logic rate_select_bits;
    logic spi_on;
    logic select_input_disable;
    logic master_select;
    logic clock_polarity_sel;
    logic clock_phase;
    logic rate_select_mid;
    logic rate_select_low;
  } smsc_ctl_type;

  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
  } smsc_sta_type;

  localparam int          BYTE_W    = 8;
  localparam int          HALF_W    = 7;
  localparam smsc_ctl_type CTL_RST  = 8'h00;
  localparam smsc_sta_type STA_RST  = 3'h0;
  localparam logic [3:0]  EDGE_LAST = 4'hF;
  localparam logic [3:0]  EDGE_ZERO = 4'h0;
  localparam logic [4:0]  TOG_LAST  = 5'h0F;
  localparam logic        SYNC_RST  = 1'b1;

  // Clock cycles per SCK half period; code 7 is held at the fastest legal rate of one cycle
  function automatic logic [HALF_W-1:0] half_cycles(input logic [2:0] rate);
    unique case (rate)
      3'h0: half_cycles = 7'h01;
      3'h1: half_cycles = 7'h02;
      3'h2: half_cycles = 7'h04;
      3'h3: half_cycles = 7'h08;
      3'h4: half_cycles = 7'h10;
      3'h5: half_cycles = 7'h20;
      3'h6: half_cycles = 7'h40;
      3'h7: half_cycles = 7'h01;
    endcase
  endfunction

endpackage

//--- smsc_sync.sv
`timescale 1ns/1ps
module smsc_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= {WIDTH{smsc_pkg::SYNC_RST}};
      sync_out <= {WIDTH{smsc_pkg::SYNC_RST}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- smsc_rate_gen.sv
`timescale 1ns/1ps
module smsc_rate_gen (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [2:0] rate,
  output logic            tick
);

  logic [smsc_pkg::HALF_W-1:0] cnt_q;
  logic [smsc_pkg::HALF_W-1:0] cnt_d;
  logic                        tick_d;

  // Half-period pulse from the selected divider
  always_comb begin
    cnt_d  = cnt_q + 7'h01;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = 7'h00;
    end else if (cnt_d == smsc_pkg::half_cycles(rate)) begin
      cnt_d  = 7'h00;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 7'h00;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end

endmodule

//--- smsc_peer.sv
`timescale 1ns/1ps
module smsc_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       slow,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  logic [7:0] sh;

  initial begin
    sh = 8'h00;
    rx = 8'h00;
  end

  // Preload on selection, MSB ready before the first leading edge
  always @(negedge sel_n) begin
    sh = tx;
  end

  // Sample on leading edge, shift on trailing edge
  always @(posedge sck) begin
    if (!sel_n) rx = {rx[6:0], mosi};
  end
  always @(negedge sck) begin
    if (!sel_n) sh = #(slow ? 30 : 1) {sh[6:0], 1'h0};
  end

  // Released line shows the inverse of the last bit
  assign miso = sel_n ? ~sh[7] : sh[7];
endmodule

//--- spi_master_slave_controller_test.sv
`timescale 1ns/1ps
module spi_master_slave_controller_test;
  logic                   mclk, nrst, ctl_wr, sta_rd, dat_wr, dat_rd;
  smsc_pkg::smsc_ctl_type ctl_wdata, ctl_rdata;
  smsc_pkg::smsc_sta_type sta_rdata;
  logic [7:0]             dat_wdata, dat_rdata, peer_tx, peer_rx, v, a, got, c;
  logic                   busy, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic                   peer_miso, tb_sck, tb_mosi, ss_n, peer_sel_n, slow, sck_p;
  logic [2:0]             r;
  logic [31:0]            seed;
  logic [7:0]             exp_q[$];
  int                     failures, checks, rises, per_cnt, per_q, h;
  wire                    sck_w  = sck_oe ? sck_out : tb_sck;
  wire                    mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire                    miso_w = miso_oe ? miso_out : peer_miso;

  smsc_core smsc_core_inst (
    .mclk(mclk), .nrst(nrst), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .sta_rd(sta_rd),
    .dat_wr(dat_wr), .dat_wdata(dat_wdata), .dat_rd(dat_rd), .ctl_rdata(ctl_rdata),
    .sta_rdata(sta_rdata), .dat_rdata(dat_rdata), .busy(busy), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
    .ss_n_in(ss_n)
  );
  smsc_peer smsc_peer_inst (
    .sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n), .slow(slow), .tx(peer_tx),
    .miso(peer_miso), .rx(peer_rx)
  );

  always #10 mclk = ~mclk;

  // SCK rise counter and period in clock cycles
  always @(posedge mclk) begin
    if (sck_w && !sck_p) begin
      per_q <= per_cnt;
      per_cnt <= 1;
      rises <= rises + 1;
    end else begin
      per_cnt <= per_cnt + 1;
    end
    sck_p <= sck_w;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Kind 0 control write, 1 data write, 2 status read, 3 data read
  task automatic req(input int k, input logic [7:0] d);
    @(negedge mclk);
    ctl_wdata = d;
    dat_wdata = d;
    {dat_rd, sta_rd, dat_wr, ctl_wr} = 4'h1 << k;
    @(negedge mclk);
    {dat_rd, sta_rd, dat_wr, ctl_wr} = 4'h0;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 5000) begin
      failures++;
      $display("[ERR] %0t transfer never ended", $time);
      final_report();
    end
  endtask

  task automatic pick_peer(input logic [7:0] t);
    @(negedge mclk);
    peer_sel_n = 1'b1;
    peer_tx = t;
    @(negedge mclk);
    peer_sel_n = 1'b0;
  endtask

  initial begin
    {mclk, nrst, ctl_wr, sta_rd, dat_wr, dat_rd, tb_sck, tb_mosi, slow, sck_p} = 10'h000;
    ctl_wdata = 8'h00;
    dat_wdata = 8'h00;
    peer_tx = 8'h00;
    ss_n = 1'b1;
    peer_sel_n = 1'b1;
    seed = 32'h4006;
    {rises, per_cnt, per_q} = 0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    // Master transfers at every rate code
    for (int i = 0; i < 8; i++) begin
      r = i[2:0];
      h = (r == 3'h7) ? 1 : (1 << r);
      slow = r[0];
      c = {r[2], 5'h1C, r[1:0]};
      req(0, c);
      cmp(ctl_rdata, c, "control readback");
      seed = lfsr(seed);
      pick_peer(seed[15:8]);
      v = seed[7:0];
      rises = 0;
      req(1, v);
      exp_q.push_back(v);
      cmp({7'h00, busy}, 8'h01, "start on data write");
      cmp({7'h00, mosi_oe}, 8'h01, "mosi driven");
      cmp({7'h00, sck_oe}, 8'h01, "sck driven");
      wait_idle();
      cmp(rises[7:0], 8'h08, "sck pulse count");
      cmp(per_q[7:0], 8'(2 * h), "sck period");
      cmp(peer_rx, exp_q.pop_front(), "peer received");
      if (r >= 3'h3 && r != 3'h7) cmp(dat_rdata, peer_tx, "master received");
      cmp({7'h00, sta_rdata.transfer_done_flag}, 8'h01, "done set");
      cmp({7'h00, sck_w}, 8'h00, "sck idle low");
      req(2, 8'h00);
      req(3, 8'h00);
      cmp({7'h00, sta_rdata.transfer_done_flag}, 8'h00, "done cleared");
    end
    // Collision during a transfer
    req(0, 8'h73);
    seed = lfsr(seed);
    pick_peer(seed[15:8]);
    a = seed[7:0];
    req(1, a);
    exp_q.push_back(a);
    req(1, ~a);
    cmp({7'h00, sta_rdata.write_collision_flag}, 8'h01, "collision");
    wait_idle();
    cmp(peer_rx, exp_q.pop_front(), "transfer kept");
    req(3, 8'h00);
    cmp({7'h00, sta_rdata.transfer_done_flag}, 8'h01, "done kept");
    req(2, 8'h00);
    pick_peer(seed[23:16]);
    req(1, seed[31:24]);
    exp_q.push_back(seed[31:24]);
    wait_idle();
    cmp(peer_rx, exp_q.pop_front(), "peer received after clear");
    cmp({7'h00, sta_rdata.write_collision_flag}, 8'h00, "collision cleared");
    req(0, 8'h7B);
    repeat (3) @(negedge mclk);
    cmp({7'h00, sck_w}, 8'h01, "sck idle high");
    // Select pin ignored, then mode fault
    ss_n = 1'b0;
    req(0, 8'h73);
    repeat (6) @(negedge mclk);
    cmp({7'h00, sta_rdata.mode_fault_flag}, 8'h00, "select ignored");
    req(0, 8'h53);
    repeat (6) @(negedge mclk);
    cmp({7'h00, sta_rdata.mode_fault_flag}, 8'h01, "mode fault");
    cmp(ctl_rdata, 8'h03, "fault disables");
    req(2, 8'h00);
    req(0, 8'h00);
    cmp({7'h00, sta_rdata.mode_fault_flag}, 8'h00, "fault cleared");
    // Slave with select disabled
    ss_n = 1'b1;
    req(0, 8'h60);
    req(1, 8'h5A);
    repeat (6) @(negedge mclk);
    cmp({7'h00, miso_oe}, 8'h00, "disable needs phase");
    req(0, 8'h64);
    repeat (6) @(negedge mclk);
    cmp({7'h00, miso_oe}, 8'h01, "select ignored");
    // Slave byte from an outside master
    req(0, 8'h40);
    seed = lfsr(seed);
    a = seed[7:0];
    v = seed[15:8];
    req(1, a);
    ss_n = 1'b0;
    repeat (8) @(negedge mclk);
    cmp({7'h00, miso_oe}, 8'h01, "slave drives");
    cmp({7'h00, sck_oe}, 8'h00, "slave leaves sck");
    for (int i = 7; i >= 0; i--) begin
      tb_mosi = v[i];
      repeat (8) @(negedge mclk);
      tb_sck = 1'b1;
      got[i] = miso_w;
      repeat (8) @(negedge mclk);
      tb_sck = 1'b0;
    end
    repeat (8) @(negedge mclk);
    cmp(got, a, "slave sent");
    cmp(dat_rdata, v, "slave received");
    cmp({7'h00, sta_rdata.transfer_done_flag}, 8'h01, "slave done");
    ss_n = 1'b1;
    repeat (6) @(negedge mclk);
    cmp({7'h00, miso_oe}, 8'h00, "slave released");
    final_report();
  end
endmodule
